// *** smc_defs.vh ***
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH
// register byte offsets
`define SMC_OFF_STOP_A     8'h00
`define SMC_OFF_STOP_B     8'h04
`define SMC_OFF_SYSCTRL    8'h08
`define SMC_OFF_STBYCTRL   8'h0c
`define SMC_OFF_STATUS     8'h10
// module stop bit positions in module_stop_ctrl_a
`define SMC_BIT_SERIAL     0
`define SMC_BIT_MFTIMER    1
`define SMC_BIT_MOTOR      2
`define SMC_BIT_CMTIMER    3
`define SMC_BIT_ADC        4
// reset values
`define SMC_STOP_A_RST     16'h001f
`define SMC_STOP_B_RST     16'h0000
`define SMC_SYSCTRL_RST    8'h01
`define SMC_STBYCTRL_RST   8'h00
// field positions
`define SMC_BIT_RAMEN      0
`define SMC_BIT_SWSTBY     7
`define SMC_BIT_FLOAT      6
// number of gated modules
`define SMC_NMOD           32
// axi responses
`define SMC_RESP_OKAY      2'b00
`define SMC_RESP_SLVERR    2'b10
`endif

// *** smc_standby_ctrl.v ***
`timescale 1ns/1ps
// Contract
// - standby pin low forces hardware standby from any mode
// - in hardware standby all logic held reset, RAM contents kept
// - standby released with reset pin low gives reset, oscillator restart
// - power-on reset release runs reset exception then program execution
// - stop bit 1 halts module after current bus cycle, CPU runs
// - stop bit 0 resumes module after current bus cycle
// - module in standby keeps its internal state initialised
// - serial, timers, compare timer, converter start stopped after reset
// - register access to a stopped module has no effect
// - interrupts of a stopped module are not serviced
// - software standby with float select 0 keeps port outputs
// - resets sampled on rising edge, interrupt pins on falling edge
// - stop bits in two 16-bit registers, 1 stops module
`include "smc_defs.vh"
module smc_standby_ctrl (
  input  wire        core_clk,          // system clock
  input  wire        rst,               // async reset, active high
  input  wire        hw_standby_n,      // hardware standby pin
  input  wire        power_on_reset_n,  // power-on reset pin
  input  wire        manual_reset_n,    // manual reset pin
  input  wire        nmi_pin,           // nonmaskable interrupt pin
  input  wire        irq_pin,           // external interrupt pin
  input  wire        sleepEnter,        // cpu sleep instruction pulse
  input  wire        wakeEvent,         // sleep and software standby wake pulse
  input  wire        busCycleEnd,       // current bus cycle ends
  input  wire [31:0] modIrqReq,         // per-module interrupt requests
  input  wire        dtcAccessReq,      // transfer controller data request
  input  wire        traceAccessReq,    // debug trace data request
  input  wire        busMasterCpu,      // access comes from the cpu
  input  wire [7:0]  s_axi_awaddr,      // write address
  input  wire        s_axi_awvalid,     // write address valid
  output reg         s_axi_awready,     // write address ready
  input  wire [31:0] s_axi_wdata,       // write data
  input  wire [3:0]  s_axi_wstrb,       // write strobes
  input  wire        s_axi_wvalid,      // write data valid
  output reg         s_axi_wready,      // write data ready
  output reg  [1:0]  s_axi_bresp,       // write response
  output reg         s_axi_bvalid,      // write response valid
  input  wire        s_axi_bready,      // write response ready
  input  wire [7:0]  s_axi_araddr,      // read address
  input  wire        s_axi_arvalid,     // read address valid
  output reg         s_axi_arready,     // read address ready
  output reg  [31:0] s_axi_rdata,       // read data
  output reg  [1:0]  s_axi_rresp,       // read response
  output reg         s_axi_rvalid,      // read response valid
  input  wire        s_axi_rready,      // read response ready
  output reg         hwStandbyActive,   // in hardware standby
  output reg         coreResetActive,   // core held in reset state
  output reg         oscRunEn,          // oscillator enable
  output reg         resetExcPulse,     // reset exception start pulse
  output reg         manualResetPulse,  // manual reset request pulse
  output reg         nmiSampled,        // nmi sampled on falling edge
  output reg         irqSampled,        // irq sampled on falling edge
  output reg         ramEnable,         // ram enable bit
  output reg  [31:0] moduleRun,         // per-module clock enable
  output reg  [31:0] moduleInit,        // per-module hold in init
  output reg  [31:0] modIrqOut,         // gated interrupt requests
  output reg         portHold,          // freeze port outputs
  output reg         portFloat,         // float port outputs
  output reg         sleepActive,       // cpu in sleep
  output reg         dtcGrant,          // transfer controller grant
  output reg         traceGrant         // debug trace grant
);
  localparam ST_RESET = 2'd0;
  localparam ST_RUN   = 2'd1;
  localparam ST_SLEEP = 2'd2;
  localparam ST_SWSTB = 2'd3;

  // standby pin is an async reset, released through two flops
  reg stbySync1_reg;
  reg stbySync2_reg;
  wire sysRst = rst | ~hw_standby_n;
  always @(posedge core_clk or posedge sysRst)
  begin
    if (sysRst)
    begin
      stbySync1_reg <= 1'b0;
      stbySync2_reg <= 1'b0;
    end
    else
    begin
      stbySync1_reg <= 1'b1;
      stbySync2_reg <= stbySync1_reg;
    end
  end
  wire intRst = ~stbySync2_reg;

  // pin synchronisers, resets on rising edge
  reg porS1_reg, porS2_reg, mresS1_reg, mresS2_reg, porPrev_reg, mresPrev_reg;
  always @(posedge core_clk or posedge intRst)
  begin
    if (intRst)
    begin
      porS1_reg    <= 1'b0;
      porS2_reg    <= 1'b0;
      mresS1_reg   <= 1'b1;
      mresS2_reg   <= 1'b1;
      porPrev_reg  <= 1'b0;
      mresPrev_reg <= 1'b1;
    end
    else
    begin
      porS1_reg    <= power_on_reset_n;
      porS2_reg    <= porS1_reg;
      mresS1_reg   <= manual_reset_n;
      mresS2_reg   <= mresS1_reg;
      porPrev_reg  <= porS2_reg;
      mresPrev_reg <= mresS2_reg;
    end
  end

  // interrupt pins sampled on falling edge
  reg nmiS1_reg, nmiS2_reg, irqS1_reg, irqS2_reg;
  always @(negedge core_clk or posedge intRst)
  begin
    if (intRst)
    begin
      nmiS1_reg <= 1'b0;
      nmiS2_reg <= 1'b0;
      irqS1_reg <= 1'b0;
      irqS2_reg <= 1'b0;
    end
    else
    begin
      nmiS1_reg <= nmi_pin;
      nmiS2_reg <= nmiS1_reg;
      irqS1_reg <= irq_pin;
      irqS2_reg <= irqS1_reg;
    end
  end

  // control registers
  reg [15:0] stopA_reg, stopB_reg;
  reg [7:0]  sysCtrl_reg, stbyCtrl_reg;
  reg [1:0]  state_reg, state_next;
  wire [31:0] stopAll = {stopB_reg, stopA_reg};

  // axi write path: take address and data in any order
  reg        awHeld_reg, wHeld_reg;
  reg [7:0]  awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0]  wStrb_reg;
  wire doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  wire wrHit = (awAddr_reg == `SMC_OFF_STOP_A) |
               (awAddr_reg == `SMC_OFF_STOP_B) |
               (awAddr_reg == `SMC_OFF_SYSCTRL) |
               (awAddr_reg == `SMC_OFF_STBYCTRL);
  always @(posedge core_clk or posedge intRst)
  begin
    if (intRst)
    begin
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      awAddr_reg    <= 8'h00;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SMC_RESP_OKAY;
      stopA_reg     <= `SMC_STOP_A_RST;
      stopB_reg     <= `SMC_STOP_B_RST;
      sysCtrl_reg   <= `SMC_SYSCTRL_RST;
      stbyCtrl_reg  <= `SMC_STBYCTRL_RST;
    end
    else
    begin
      s_axi_awready <= ~awHeld_reg & s_axi_awvalid & ~s_axi_awready;
      s_axi_wready  <= ~wHeld_reg & s_axi_wvalid & ~s_axi_wready;
      if (s_axi_awvalid & s_axi_awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
        // stop registers only change for cpu writes
        if (awAddr_reg == `SMC_OFF_STOP_A && busMasterCpu)
        begin
          if (wStrb_reg[0]) stopA_reg[7:0]  <= wData_reg[7:0];
          if (wStrb_reg[1]) stopA_reg[15:8] <= wData_reg[15:8];
        end
        if (awAddr_reg == `SMC_OFF_STOP_B && busMasterCpu)
        begin
          if (wStrb_reg[0]) stopB_reg[7:0]  <= wData_reg[7:0];
          if (wStrb_reg[1]) stopB_reg[15:8] <= wData_reg[15:8];
        end
        if (awAddr_reg == `SMC_OFF_SYSCTRL && wStrb_reg[0])
          sysCtrl_reg <= wData_reg[7:0];
        if (awAddr_reg == `SMC_OFF_STBYCTRL && wStrb_reg[0])
          stbyCtrl_reg <= wData_reg[7:0];
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi read path, one cycle after address
  always @(posedge core_clk or posedge intRst)
  begin
    if (intRst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SMC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SMC_RESP_OKAY;
        case (s_axi_araddr)
          `SMC_OFF_STOP_A:   s_axi_rdata <= {16'h0000, stopA_reg};
          `SMC_OFF_STOP_B:   s_axi_rdata <= {16'h0000, stopB_reg};
          `SMC_OFF_SYSCTRL:  s_axi_rdata <= {24'h000000, sysCtrl_reg};
          `SMC_OFF_STBYCTRL: s_axi_rdata <= {24'h000000, stbyCtrl_reg};
          `SMC_OFF_STATUS:   s_axi_rdata <= {28'h0000000, portHold,
                                             sleepActive, state_reg};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SMC_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // power mode sequencer
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET:
        if (porS2_reg) state_next = ST_RUN;
      ST_RUN:
        if (sleepEnter)
          state_next = stbyCtrl_reg[`SMC_BIT_SWSTBY] ? ST_SWSTB : ST_SLEEP;
      ST_SLEEP:
        if (wakeEvent) state_next = ST_RUN;
      ST_SWSTB:
        if (wakeEvent) state_next = ST_RUN;
      default:
        state_next = ST_RESET;
    endcase
    if (!porS2_reg) state_next = ST_RESET;
    else if (!mresS2_reg && state_reg != ST_RESET) state_next = ST_RUN;
  end

  // sequencer state and mode outputs
  always @(posedge core_clk or posedge intRst)
  begin
    if (intRst)
    begin
      state_reg        <= ST_RESET;
      hwStandbyActive  <= 1'b1;
      coreResetActive  <= 1'b1;
      oscRunEn         <= 1'b0;
      resetExcPulse    <= 1'b0;
      manualResetPulse <= 1'b0;
      nmiSampled       <= 1'b0;
      irqSampled       <= 1'b0;
      ramEnable        <= 1'b0;
      portHold         <= 1'b0;
      portFloat        <= 1'b0;
      sleepActive      <= 1'b0;
      dtcGrant         <= 1'b0;
      traceGrant       <= 1'b0;
    end
    else
    begin
      state_reg        <= state_next;
      hwStandbyActive  <= 1'b0;
      coreResetActive  <= (state_next == ST_RESET);
      oscRunEn         <= (state_next != ST_SWSTB);
      resetExcPulse    <= porS2_reg & ~porPrev_reg;
      manualResetPulse <= ~mresS2_reg & mresPrev_reg & porS2_reg;
      nmiSampled       <= nmiS2_reg;
      irqSampled       <= irqS2_reg;
      ramEnable        <= sysCtrl_reg[`SMC_BIT_RAMEN];
      portHold         <= (state_next == ST_SWSTB) &
                          ~stbyCtrl_reg[`SMC_BIT_FLOAT];
      portFloat        <= (state_next == ST_SWSTB) &
                          stbyCtrl_reg[`SMC_BIT_FLOAT];
      sleepActive      <= (state_next == ST_SLEEP);
      dtcGrant         <= dtcAccessReq & (state_next == ST_RUN);
      traceGrant       <= traceAccessReq & (state_next == ST_RUN);
    end
  end

  // per-module gating, applied at bus cycle end
  genvar i;
  generate
    for (i = 0; i < `SMC_NMOD; i = i + 1)
    begin : gModule
      always @(posedge core_clk or posedge intRst)
      begin
        if (intRst)
        begin
          moduleRun[i]  <= 1'b0;
          moduleInit[i] <= 1'b1;
          modIrqOut[i]  <= 1'b0;
        end
        else
        begin
          if (busCycleEnd)
          begin
            moduleRun[i]  <= ~stopAll[i];
            moduleInit[i] <= stopAll[i];
          end
          modIrqOut[i] <= modIrqReq[i] & moduleRun[i];
        end
      end
    end
  endgenerate
endmodule // smc_standby_ctrl

// *** smc_standby_ctrl_chk.sv ***
`timescale 1ns/1ps
// pin-level watch on standby, module gating and grants
module smc_chk (
  input logic        core_clk,         // clock
  input logic        rst,              // reset
  input logic        hw_standby_n,     // standby pin
  input logic        power_on_reset_n, // reset pin
  input logic        nmi_pin,          // nmi pin
  input logic        busCycleEnd,      // bus cycle end
  input logic [31:0] modIrqReq,        // module irqs
  input logic        s_axi_awready,    // aw ready
  input logic        s_axi_arready,    // ar ready
  input logic        hwStandbyActive,  // standby flag
  input logic        coreResetActive,  // reset flag
  input logic        oscRunEn,         // oscillator
  input logic        resetExcPulse,    // exception pulse
  input logic        nmiSampled,       // nmi echo
  input logic [31:0] moduleRun,        // run mask
  input logic [31:0] moduleInit,       // init mask
  input logic [31:0] modIrqOut,        // gated irqs
  input logic        sleepActive,      // sleep flag
  input logic        dtcGrant,         // dtc grant
  input logic        traceGrant        // trace grant
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // release steps of hardware standby
  sequence sqHwRel;
    $rose(hw_standby_n) && !power_on_reset_n;
  endsequence
  sequence sqPorRel;
    $rose(power_on_reset_n) && hw_standby_n;
  endsequence
  // standby, reset and gating relations
  AST_HW_ENTRY: assert property (!hw_standby_n |->
    hwStandbyActive && coreResetActive)
    else $error("standby pin low but block not in standby");
  AST_HW_HELD: assert property (!hw_standby_n |->
    moduleRun == 32'h0 && &moduleInit &&
    !s_axi_awready && !s_axi_arready)
    else $error("logic running during hardware standby");
  AST_HW_REL: assert property (sqHwRel |-> coreResetActive
    ##[1:6] (oscRunEn && coreResetActive))
    else $error("no reset state with oscillator after standby release");
  AST_POR_REL: assert property (sqPorRel |-> ##[1:6] resetExcPulse
    ##[0:4] !coreResetActive)
    else $error("no reset exception after reset pin release");
  AST_INT_REL: assert property ($rose(hw_standby_n) |->
    hwStandbyActive ##[1:4] !hwStandbyActive)
    else $error("internal reset release not synchronous");
  AST_GATE_EDGE: assert property (disable iff (rst || !hw_standby_n)
    $changed(moduleRun) |-> $past(busCycleEnd))
    else $error("run mask changed outside a bus cycle end");
  AST_INIT_HOLD: assert property (moduleInit == ~moduleRun)
    else $error("stopped module not held initialised");
  AST_IRQ_GATE: assert property (disable iff (rst || !hw_standby_n)
    $stable(modIrqReq) && $stable(moduleRun) |->
    modIrqOut == (modIrqReq & moduleRun))
    else $error("interrupt of a stopped module passed");
  AST_SLEEP_GNT: assert property (sleepActive && $past(sleepActive) |->
    !dtcGrant && !traceGrant)
    else $error("grant given during sleep");
  AST_NMI_FALL: assert property (@(negedge core_clk)
    disable iff (rst || !hw_standby_n)
    $rose(nmi_pin) ##1 nmi_pin[*3] |-> nmiSampled)
    else $error("nmi not taken on falling edges");
endmodule // smc_chk

bind smc_standby_ctrl smc_chk u_chk (.*);

// *** smc_board_model.sv ***
`timescale 1ns/1ps
// board logic around the standby and reset pins
module smc_board_model #(
  parameter STAB_CYCLES = 16  // oscillation settling in clocks
) (
  input  wire core_clk,        // system clock
  input  wire standbyReq,      // bench asks for standby
  output reg  hw_standby_n,    // standby pin
  output reg  power_on_reset_n // power-on reset pin
);
  // boot mode strap, fixed for the whole run, standby included
  localparam [3:0] BOOT_STRAP = 4'h0;
  // power-up, standby entry and ordered release
  initial
  begin
    hw_standby_n = 1'b1;
    power_on_reset_n = 1'b0;
    repeat (STAB_CYCLES) @(posedge core_clk);
    power_on_reset_n <= 1'b1;
    forever
    begin
      @(posedge core_clk);
      if (standbyReq && hw_standby_n)
      begin
        power_on_reset_n <= 1'b0;
        hw_standby_n <= 1'b0;
      end
      else if (!standbyReq && !hw_standby_n)
      begin
        hw_standby_n <= 1'b1;
        repeat (STAB_CYCLES) @(posedge core_clk);
        power_on_reset_n <= 1'b1;
      end
    end
  end
endmodule // smc_board_model

// *** smc_standby_ctrl_test.sv ***
`timescale 1ns/1ps
`include "smc_defs.vh"
// register, gating, sleep and standby sequences
module smc_standby_ctrl_test;
  localparam [1:0] OK = `SMC_RESP_OKAY;
  localparam [1:0] ER = `SMC_RESP_SLVERR;
  logic core_clk = 0, rst = 1, standbyReq = 0, seen = 0;
  logic hw_standby_n, power_on_reset_n, s_axi_awready, s_axi_wready;
  logic manual_reset_n = 1, nmi_pin = 0, irq_pin = 0, busMasterCpu = 1;
  logic sleepEnter = 0, wakeEvent = 0, busCycleEnd = 0;
  logic dtcAccessReq = 0, traceAccessReq = 0, s_axi_bready = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_rready = 0;
  logic s_axi_arvalid = 0, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] modIrqReq = 0, s_axi_wdata = 0, s_axi_rdata;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic hwStandbyActive, coreResetActive, oscRunEn, resetExcPulse;
  logic manualResetPulse, nmiSampled, irqSampled, ramEnable, portHold;
  logic portFloat, sleepActive, dtcGrant, traceGrant;
  logic [31:0] moduleRun, moduleInit, modIrqOut;
  int failures = 0, num_checks = 0;
  smc_standby_ctrl u_dut (.*);
  smc_board_model u_brd (.*);
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  task chk(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // register write, each channel released when taken
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er);
  endtask
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // one-cycle pulse of {busCycleEnd, sleepEnter, wakeEvent}
  task pls(input [2:0] k);
    @(posedge core_clk);
    {busCycleEnd, sleepEnter, wakeEvent} <= k;
    @(posedge core_clk);
    {busCycleEnd, sleepEnter, wakeEvent} <= 3'b000;
    repeat (3) @(posedge core_clk);
  endtask
  // hang guard
  initial
  begin
    #100us;
    failures++;
    report_and_stop;
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 0;
    repeat (40) @(posedge core_clk);
    rd(`SMC_OFF_STOP_A, 32'h1f, OK);
    rd(`SMC_OFF_STOP_B, 32'h0, OK);
    pls(3'b100);
    chk(moduleRun, 32'hffffffe0);
    chk(moduleInit, 32'h1f);
    wr(`SMC_OFF_STOP_A, 32'h0, OK);
    chk(moduleRun, 32'hffffffe0);
    pls(3'b100);
    chk(moduleRun, 32'hffffffff);
    wr(`SMC_OFF_STOP_B, 32'h8002, OK);
    pls(3'b100);
    chk(moduleRun, 32'h7ffdffff);
    chk(moduleInit, 32'h80020000);
    rd(`SMC_OFF_STOP_B, 32'h8002, OK);
    busMasterCpu <= 0;
    wr(`SMC_OFF_STOP_A, 32'hffff, OK);
    busMasterCpu <= 1;
    rd(`SMC_OFF_STOP_A, 32'h0, OK);
    wr(8'h40, 32'h1, ER);
    rd(8'h40, 32'h0, ER);
    modIrqReq <= 32'hffffffff;
    repeat (3) @(posedge core_clk);
    chk(modIrqOut, 32'h7ffdffff);
    {dtcAccessReq, traceAccessReq} <= 2'b11;
    pls(3'b010);
    chk({sleepActive, dtcGrant, traceGrant}, 32'h4);
    pls(3'b001);
    chk({sleepActive, dtcGrant, traceGrant}, 32'h3);
    wr(`SMC_OFF_STBYCTRL, 32'h80, OK);
    pls(3'b010);
    chk({portHold, portFloat, oscRunEn}, 32'h4);
    pls(3'b001);
    {nmi_pin, irq_pin} <= 2'b11;
    repeat (4) @(posedge core_clk);
    chk({nmiSampled, irqSampled}, 32'h3);
    // soft standby with floating ports, left by a manual reset
    wr(`SMC_OFF_STBYCTRL, 32'hc0, OK);
    pls(3'b010);
    chk({portHold, portFloat, oscRunEn}, 32'h2);
    rd(`SMC_OFF_STATUS, 32'h3, OK);
    manual_reset_n <= 0;
    repeat (4) @(posedge core_clk);
    chk({manualResetPulse, portFloat, oscRunEn}, 32'h5);
    manual_reset_n <= 1;
    wr(`SMC_OFF_SYSCTRL, 32'h0, OK);
    standbyReq <= 1;
    repeat (4) @(posedge core_clk);
    chk({hwStandbyActive, coreResetActive}, 32'h3);
    chk(moduleRun, 32'h0);
    standbyReq <= 0;
    repeat (6) @(posedge core_clk);
    chk({power_on_reset_n, coreResetActive, oscRunEn}, 32'h3);
    repeat (30)
    begin
      @(posedge core_clk);
      seen |= resetExcPulse;
    end
    chk(seen, 32'h1);
    chk({coreResetActive, ramEnable}, 32'h1);
    rd(`SMC_OFF_STOP_A, 32'h1f, OK);
    report_and_stop;
  end
endmodule // smc_standby_ctrl_test
